// ---- core/rtcs_port.sv ----
`timescale 1ns/1ps
`include "rtcs_cfg.svh"
// Overview of operation
// - Acknowledge every received byte, a matching address included.
// - Shift bytes most significant bit first.
// - Stop or repeated start ends a transfer.
// - Start begins, stop ends, in both directions.
// - First byte is address 1101000 plus direction.
// - Direction one means read after address acknowledge.
// - Matching address gets data line pulled low.
// - First written byte loads the register pointer.
// - Store each data byte, acknowledge, advance pointer; with buffer and holding word full, a new byte overwrites the held one.
// - Read starts from the register at pointer.
// - Pointer persists across transfers.
// - Keep sending until a not-acknowledge arrives.
// - Release data line after a not-acknowledge.
// - Data changes with clock low; else start/stop.
// - Hold acknowledge low through the ninth clock high.
module rtcs_port import rtcs_pkg::*; #(
	parameter logic [6:0] SLAVE_ADDR = `RTCS_SLAVE_ADDR,
	parameter int BW = `RTCS_BYTE_W
) (
	input wire logic clk, // System clock, 50 MHz.
	input wire logic sys_rst, // Synchronous reset, active high.
	input wire logic clkEn, // Freezes all state while low.
	input wire logic sclIn, // Serial clock pin level.
	input wire logic sdaIn, // Serial data pin level.
	output logic sdaOut, // Serial data drive value, always low.
	output logic sdaOeN, // Serial data enable, low while pulling low.
	output logic [BW-1:0] rdAddr, // Register the read data must show.
	input wire logic [BW-1:0] rdData, // Contents of register rdAddr.
	output logic wrValid, // A write word is offered.
	output logic [BW-1:0] wrAddr, // Register to be written.
	output logic [BW-1:0] wrData, // Value to be written.
	input wire logic wrReady // Register file takes the write word.
);

	logic [2:0] sclSync_ff;
	logic [2:0] sdaSync_ff;
	logic sclRise;
	logic sclFall;
	logic startSeen;
	logic stopSeen;
	rtcs_state_t state_ff;
	rtcs_kind_t kind_ff;
	logic [3:0] bitCnt_ff;
	logic [BW-1:0] rxShift_ff;
	logic [BW-1:0] txShift_ff;
	logic [BW-1:0] ptr_ff;
	logic readMode_ff;
	logic masterAck_ff;
	logic sdaOeN_ff;
	logic sdaOut_ff;
	logic pendValid_ff;
	logic [2*BW-1:0] pendWord_ff;
	logic byteDone;
	logic addrMatch;
	logic [BW-1:0] ptrNext;

	rtcs_strm_if #(.W(2*BW)) toBuf ();
	rtcs_strm_if #(.W(2*BW)) fromBuf ();

	// Checked at elaboration: the bit counters assume whole 8-bit bytes.
	if (BW != 8) begin : badWidth
		$error("rtcs_port shifts whole 8-bit bytes only");
	end

	// Pointer arithmetic wraps at the byte width.
	function automatic logic [BW-1:0] incPtr(input logic [BW-1:0] p);
		incPtr = p + {{(BW-1){1'b0}}, 1'b1};
	endfunction

	// Pins come from another domain: two flops, then a history flop.
	// Only stages 1 and 2 are looked at by edge logic.
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			sclSync_ff <= 3'h7;
			sdaSync_ff <= 3'h7;
		end else if (clkEn) begin
			sclSync_ff <= {sclSync_ff[1:0], sclIn};
			sdaSync_ff <= {sdaSync_ff[1:0], sdaIn};
		end
	end

	// Data moving while the clock is high marks a start or a stop.
	assign sclRise = clkEn & sclSync_ff[1] & ~sclSync_ff[2];
	assign sclFall = clkEn & ~sclSync_ff[1] & sclSync_ff[2];
	assign startSeen = clkEn & sclSync_ff[1] & sclSync_ff[2] & ~sdaSync_ff[1] & sdaSync_ff[2];
	assign stopSeen = clkEn & sclSync_ff[1] & sclSync_ff[2] & sdaSync_ff[1] & ~sdaSync_ff[2];
	assign byteDone = sclFall && state_ff == ST_RXBYTE && bitCnt_ff == `RTCS_BITS_IN;
	assign addrMatch = rxShift_ff[BW-1:1] == SLAVE_ADDR;
	assign ptrNext = incPtr(ptr_ff);

	// Link sequencer: bits sampled on clock rise, line changed on fall.
	// The clock pin is only ever sampled; nothing here can stretch it.
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			state_ff <= ST_IDLE;
			kind_ff <= KIND_ADDR;
			bitCnt_ff <= 4'h0;
			rxShift_ff <= '0;
			txShift_ff <= '0;
			readMode_ff <= 1'h0;
			masterAck_ff <= 1'h0;
			sdaOeN_ff <= 1'h1;
		end else if (startSeen) begin
			// A repeated start simply opens a fresh transfer.
			state_ff <= ST_RXBYTE;
			kind_ff <= KIND_ADDR;
			bitCnt_ff <= 4'h0;
			sdaOeN_ff <= 1'h1;
		end else if (stopSeen) begin
			state_ff <= ST_IDLE;
			sdaOeN_ff <= 1'h1;
		end else begin
			case (state_ff)
				ST_RXBYTE: begin
					if (sclRise && bitCnt_ff != `RTCS_BITS_IN) begin
						rxShift_ff <= {rxShift_ff[BW-2:0], sdaSync_ff[1]};
						bitCnt_ff <= bitCnt_ff + 4'h1;
					end else if (byteDone) begin
						if (kind_ff == KIND_ADDR && !addrMatch) begin
							state_ff <= ST_IDLE;
						end else begin
							state_ff <= ST_RXACK;
							sdaOeN_ff <= 1'h0;
							if (kind_ff == KIND_ADDR) begin
								readMode_ff <= rxShift_ff[0] == `RTCS_DIR_READ;
							end
						end
					end
				end
				ST_RXACK: begin
					// Held low from the fall before the ninth pulse to its fall.
					if (sclFall) begin
						bitCnt_ff <= 4'h0;
						if (kind_ff == KIND_ADDR && readMode_ff) begin
							// Pointer was left by the last transfer, or just set.
							txShift_ff <= rdData;
							sdaOeN_ff <= rdData[BW-1];
							state_ff <= ST_TXBYTE;
						end else begin
							sdaOeN_ff <= 1'h1;
							state_ff <= ST_RXBYTE;
							kind_ff <= kind_ff == KIND_ADDR ? KIND_PTR : KIND_DATA;
						end
					end
				end
				ST_TXBYTE: begin
					if (sclFall) begin
						if (bitCnt_ff == `RTCS_BITS_OUT) begin
							sdaOeN_ff <= 1'h1;
							state_ff <= ST_TXACK;
						end else begin
							txShift_ff <= {txShift_ff[BW-2:0], 1'b0};
							sdaOeN_ff <= txShift_ff[BW-2];
							bitCnt_ff <= bitCnt_ff + 4'h1;
						end
					end
				end
				ST_TXACK: begin
					// The master answers each byte; low means send another.
					if (sclRise) begin
						masterAck_ff <= ~sdaSync_ff[1];
					end else if (sclFall) begin
						bitCnt_ff <= 4'h0;
						if (masterAck_ff) begin
							txShift_ff <= rdData;
							sdaOeN_ff <= rdData[BW-1];
							state_ff <= ST_TXBYTE;
						end else begin
							sdaOeN_ff <= 1'h1;
							state_ff <= ST_IDLE;
						end
					end
				end
				default: begin
					sdaOeN_ff <= 1'h1;
				end
			endcase
		end
	end

	// Register pointer is never cleared by a start, only by reset.
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			ptr_ff <= '0;
		end else if (byteDone && kind_ff == KIND_PTR) begin
			ptr_ff <= rxShift_ff;
		end else if (byteDone && kind_ff == KIND_DATA) begin
			ptr_ff <= ptrNext;
		end else if (sclFall && state_ff == ST_TXBYTE && bitCnt_ff == `RTCS_BITS_OUT) begin
			ptr_ff <= ptrNext;
		end
	end

	// Received data words wait here until the buffer has room. The master
	// cannot be held off, so a full buffer plus a full holding word while
	// a fourth byte lands loses the holding word, the newest waiting one.
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			pendValid_ff <= 1'h0;
			pendWord_ff <= '0;
		end else if (byteDone && kind_ff == KIND_DATA) begin
			pendValid_ff <= 1'h1;
			pendWord_ff <= {ptr_ff, rxShift_ff};
		end else if (pendValid_ff && toBuf.ready && clkEn) begin
			pendValid_ff <= 1'h0;
		end
	end

	// Data drive value is a constant low; only the enable moves.
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			sdaOut_ff <= 1'h0;
		end else if (clkEn) begin
			sdaOut_ff <= 1'h0;
		end
	end

	assign toBuf.valid = pendValid_ff;
	assign toBuf.data = pendWord_ff;
	assign fromBuf.ready = wrReady;

	rtcs_buf #(.W(2*BW), .DEPTH(`RTCS_BUF_DEPTH)) wrBuf (
		.clk(clk),
		.sys_rst(sys_rst),
		.clkEn(clkEn),
		.inS(toBuf),
		.outS(fromBuf)
	);

	assign sdaOut = sdaOut_ff;
	assign sdaOeN = sdaOeN_ff;
	assign rdAddr = ptr_ff;
	assign wrValid = fromBuf.valid;
	assign wrAddr = fromBuf.data[2*BW-1:BW];
	assign wrData = fromBuf.data[BW-1:0];

	sequence startSeq;
		startSeen;
	endsequence

	sequence addrByteEnd;
		byteDone && kind_ff == KIND_ADDR && !startSeen && !stopSeen;
	endsequence

	addrAck_a: assert property (@(posedge clk) disable iff (sys_rst)
		addrByteEnd and addrMatch |=> !sdaOeN_ff && state_ff == ST_RXACK)
		else $error("matching address not acknowledged");

	foreignAddr_a: assert property (@(posedge clk) disable iff (sys_rst)
		addrByteEnd and !addrMatch |=> sdaOeN_ff && state_ff == ST_IDLE)
		else $error("foreign address not ignored");

	startOpens_a: assert property (@(posedge clk) disable iff (sys_rst)
		startSeq |=> state_ff == ST_RXBYTE && kind_ff == KIND_ADDR && bitCnt_ff == 4'h0)
		else $error("start did not open an address byte");

	stopCloses_a: assert property (@(posedge clk) disable iff (sys_rst)
		stopSeen && !startSeen |=> state_ff == ST_IDLE && sdaOeN_ff)
		else $error("stop did not end the transfer");

	ackHeld_a: assert property (@(posedge clk) disable iff (sys_rst)
		state_ff == ST_RXACK |-> !sdaOeN_ff)
		else $error("acknowledge released early");

	txMsbFirst_a: assert property (@(posedge clk) disable iff (sys_rst)
		state_ff == ST_TXBYTE |-> sdaOeN_ff == txShift_ff[BW-1])
		else $error("transmit bit is not the top of the shifter");

	ptrLoad_a: assert property (@(posedge clk) disable iff (sys_rst)
		byteDone && kind_ff == KIND_PTR && !startSeen && !stopSeen
		|=> ptr_ff == $past(rxShift_ff))
		else $error("pointer byte not loaded");

	readStep_a: assert property (@(posedge clk) disable iff (sys_rst)
		sclFall && state_ff == ST_TXBYTE && bitCnt_ff == `RTCS_BITS_OUT && !startSeen
		|=> ptr_ff == incPtr($past(ptr_ff)) && state_ff == ST_TXACK)
		else $error("pointer did not step after a read byte");

	nackEnds_a: assert property (@(posedge clk) disable iff (sys_rst)
		sclFall && state_ff == ST_TXACK && !masterAck_ff && !startSeen
		|=> state_ff == ST_IDLE && sdaOeN_ff)
		else $error("line not released after not-acknowledge");

	firstRead_a: assert property (@(posedge clk) disable iff (sys_rst)
		sclFall && state_ff == ST_RXACK && kind_ff == KIND_ADDR && readMode_ff && !startSeen
		|=> state_ff == ST_TXBYTE && txShift_ff == $past(rdData))
		else $error("read did not start from the pointed register");

endmodule

// ---- core/rtcs_cfg.svh ----
`ifndef RTCS_CFG_SVH
`define RTCS_CFG_SVH

// Seven-bit bus address that this port answers to.
`define RTCS_SLAVE_ADDR 7'h68
// Width of one byte on the serial line and of the register pointer.
`define RTCS_BYTE_W 8
// Bit count reached when a whole byte has been shifted in.
`define RTCS_BITS_IN 4'h8
// Fall count at which the last transmitted bit has been on the line.
`define RTCS_BITS_OUT 4'h7
// Value of the direction bit that selects a read.
`define RTCS_DIR_READ 1'h1
// Depth of the write-data buffer; the buffer structure serves only two.
`define RTCS_BUF_DEPTH 2

`endif

// ---- core/rtcs_pkg.sv ----
package rtcs_pkg;

	// Link-facing sequencer states.
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_RXBYTE,
		ST_RXACK,
		ST_TXBYTE,
		ST_TXACK
	} rtcs_state_t;

	// What the byte now being received means.
	typedef enum logic [1:0] {
		KIND_ADDR,
		KIND_PTR,
		KIND_DATA
	} rtcs_kind_t;

endpackage

// ---- core/rtcs_strm_if.sv ----
`timescale 1ns/1ps
// Valid/ready word stream between the sequencer and the write buffer.
interface rtcs_strm_if #(
	parameter int W = 16
);
	logic valid;
	logic ready;
	logic [W-1:0] data;

	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface

// ---- core/rtcs_buf.sv ----
`timescale 1ns/1ps
`include "rtcs_cfg.svh"
// Two-entry buffer: one output register plus one skid register.
// Ready towards the source is a flop, so the source sees it without a
// combinational path through the sink's ready.
module rtcs_buf import rtcs_pkg::*; #(
	parameter int W = 16,
	parameter int DEPTH = `RTCS_BUF_DEPTH
) (
	input wire logic clk, // System clock.
	input wire logic sys_rst, // Synchronous reset, active high.
	input wire logic clkEn, // Freezes all state while low.
	rtcs_strm_if.snk inS, // Words from the sequencer.
	rtcs_strm_if.src outS // Words towards the register file.
);

	logic [W-1:0] skidData_ff;
	logic skidValid_ff;
	logic outValid_ff;
	logic [W-1:0] outData_ff;
	logic push;
	logic pop;

	// Checked at elaboration: the skid structure holds exactly two words.
	if (DEPTH != 2 || W < 1) begin : badCfg
		$error("rtcs_buf serves exactly two entries of nonzero width");
	end

	// A full skid register is the only reason to refuse a word.
	assign inS.ready = ~skidValid_ff;
	assign outS.valid = outValid_ff;
	assign outS.data = outData_ff;
	assign push = inS.valid & ~skidValid_ff;
	assign pop = outValid_ff & outS.ready;

	// Output register refills from the skid first so order is kept.
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			outValid_ff <= 1'h0;
			outData_ff <= '0;
			skidValid_ff <= 1'h0;
			skidData_ff <= '0;
		end else if (clkEn) begin
			if (!outValid_ff || pop) begin
				if (skidValid_ff) begin
					outData_ff <= skidData_ff;
					outValid_ff <= 1'h1;
					skidValid_ff <= 1'h0;
				end else begin
					outValid_ff <= push;
					if (push) begin
						outData_ff <= inS.data;
					end
				end
			end else if (push) begin
				skidData_ff <= inS.data;
				skidValid_ff <= 1'h1;
			end
		end
	end

	// A held output word must stay put until the sink takes it.
	holdOut_a: assert property (@(posedge clk) disable iff (sys_rst)
		outValid_ff && !outS.ready && clkEn |=> outValid_ff && $stable(outData_ff))
		else $error("buffered write word changed before it was taken");

endmodule

// ---- tb/rtcs_master.sv ----
`timescale 1ns/1ps
// Behavioural bus master; the device only ever sees these two lines.
// Every line change lands on a system clock edge; one bit takes eight clocks.
module rtcs_master (
	input wire logic clk, // Bench clock that paces the link.
	output logic sclM, // Clock line drive, one means released.
	output logic sdaM, // Data line drive, one means released.
	input wire logic sda // Resolved data line level.
);
	// Both lines idle high; the clock stands still between frames.
	initial begin
		sclM = 1'b1;
		sdaM = 1'b1;
	end
	// Start or repeated start: data falls while the clock is high.
	// The first wait lets the port drop a pending acknowledge before the clock rises.
	task automatic start();
		repeat (2) @(posedge clk);
		sdaM <= 1'b1;
		repeat (2) @(posedge clk);
		sclM <= 1'b1;
		repeat (4) @(posedge clk);
		sdaM <= 1'b0;
		repeat (4) @(posedge clk);
		sclM <= 1'b0;
	endtask
	// One pulse; the line is sampled twice so a wobble in the high phase shows.
	task automatic bit_io(input logic b, output logic s);
		repeat (2) @(posedge clk);
		sdaM <= b;
		repeat (2) @(posedge clk);
		sclM <= 1'b1;
		@(posedge clk);
		s = sda;
		repeat (2) @(posedge clk);
		s = s | sda;
		@(posedge clk);
		sclM <= 1'b0;
	endtask
	// Eight bits then the acknowledge slot.
	task automatic xfer(input logic [7:0] tx, input logic ackIn, output logic [7:0] rx,
		output logic ackOut);
		for (int i = 7; i >= 0; i--) begin
			bit_io(tx[i], rx[i]);
		end
		bit_io(ackIn, ackOut);
	endtask
	// Stop: data rises while the clock is high.
	task automatic stop();
		repeat (2) @(posedge clk);
		sdaM <= 1'b0;
		repeat (2) @(posedge clk);
		sclM <= 1'b1;
		repeat (4) @(posedge clk);
		sdaM <= 1'b1;
		repeat (4) @(posedge clk);
	endtask
endmodule

// ---- tb/tb_top.sv ----
`timescale 1ns/1ps
// Self-checking bench: master model on the wire, register array behind the port.
module tb_top;
	logic clk = 1'b0;
	logic sysRst = 1'b1;
	logic wrReady = 1'b1;
	logic sdaOeN, sdaOut, wrValid, sclM, sdaM, ack;
	logic [7:0] rdAddr, wrAddr, wrData, rdData, rx;
	wire logic sdaLine;
	logic [7:0] regs [0:255];
	int bad_count = 0;
	int n_checks = 0;

	// The data line has a pull-up; either party can only pull it low.
	assign sdaLine = sdaM & (sdaOeN | sdaOut);
	assign rdData = regs[rdAddr];
	initial begin
		forever #10 clk = ~clk;
	end
	rtcs_port u_dut (.clk(clk), .sys_rst(sysRst), .clkEn(1'b1), .sclIn(sclM),
		.sdaIn(sdaLine), .sdaOut(sdaOut), .sdaOeN(sdaOeN), .rdAddr(rdAddr), .rdData(rdData),
		.wrValid(wrValid), .wrAddr(wrAddr), .wrData(wrData), .wrReady(wrReady));
	rtcs_master u_mst (.clk(clk), .sclM(sclM), .sdaM(sdaM), .sda(sdaLine));
	// Writes land only when the sink is ready, so a stall holds them in the port.
	always @(posedge clk) begin
		if (wrValid && wrReady) begin
			regs[wrAddr] <= wrData;
		end
	end

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		n_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wb(input logic [7:0] b);
		u_mst.xfer(b, 1'b1, rx, ack);
	endtask
	task automatic rb(input logic nack);
		u_mst.xfer(8'hFF, nack, rx, ack);
	endtask
	// Ten cycles cover the five the port needs after a byte; checks then look between edges.
	task automatic settle();
		repeat (10) @(posedge clk);
		#7;
	endtask
	task automatic t_reset();
		check({7'h0, sdaOeN}, 8'h01);
		check({7'h0, sdaOut}, 8'h00);
		check(rdAddr, 8'h00);
		check({7'h0, wrValid}, 8'h00);
	endtask
	// Three data bytes while the sink stalls; none may be lost.
	task automatic t_write_stall();
		@(posedge clk);
		wrReady <= 1'b0;
		#7;
		u_mst.start();
		wb(8'hD0);
		check({7'h0, ack}, 8'h00);
		wb(8'h10);
		check({7'h0, ack}, 8'h00);
		wb(8'hA5);
		wb(8'h3C);
		wb(8'h77);
		check({7'h0, ack}, 8'h00);
		u_mst.stop();
		settle();
		check({7'h0, wrValid}, 8'h01);
		check(regs[8'h10], 8'h4A);
		check(rdAddr, 8'h13);
		@(posedge clk);
		wrReady <= 1'b1;
		settle();
		check(regs[8'h10], 8'hA5);
		check(regs[8'h11], 8'h3C);
		check(regs[8'h12], 8'h77);
		check({7'h0, wrValid}, 8'h00);
	endtask
	// Pointer write, repeated start, then a three-byte read.
	task automatic t_read_rs();
		u_mst.start();
		wb(8'hD0);
		check({7'h0, ack}, 8'h00);
		wb(8'h10);
		u_mst.start();
		wb(8'hD1);
		check({7'h0, ack}, 8'h00);
		rb(1'b0);
		check(rx, 8'hA5);
		rb(1'b0);
		check(rx, 8'h3C);
		rb(1'b1);
		check(rx, 8'h77);
		check({7'h0, ack}, 8'h01);
		#110;
		check({7'h0, sdaOeN}, 8'h01);
		u_mst.stop();
		settle();
		check(rdAddr, 8'h13);
	endtask
	task automatic t_read_cur();
		u_mst.start();
		wb(8'hD1);
		check({7'h0, ack}, 8'h00);
		rb(1'b1);
		check(rx, 8'h49);
		u_mst.stop();
		settle();
	endtask
	// A foreign address; our own address later in that frame must not wake the port.
	task automatic t_foreign();
		u_mst.start();
		wb(8'hA0);
		check({7'h0, ack}, 8'h01);
		wb(8'hD1);
		check({7'h0, ack}, 8'h01);
		rb(1'b1);
		check(rx, 8'hFF);
		u_mst.stop();
		settle();
		check(rdAddr, 8'h14);
	endtask
	// Zero data bytes, then a data byte cut short by a fresh start.
	task automatic t_abort();
		u_mst.start();
		wb(8'hD0);
		wb(8'h30);
		check({7'h0, ack}, 8'h00);
		repeat (3) begin
			u_mst.bit_io(1'b1, ack);
		end
		u_mst.start();
		u_mst.stop();
		settle();
		check({7'h0, wrValid}, 8'h00);
		check(rdAddr, 8'h30);
	endtask
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	initial begin
		for (int i = 0; i < 256; i++) begin
			regs[i] = 8'(i) ^ 8'h5A;
		end
		repeat (8) @(posedge clk);
		sysRst <= 1'b0;
		repeat (4) @(posedge clk);
		#7;
		t_reset();
		t_write_stall();
		t_read_rs();
		t_read_cur();
		t_foreign();
		t_abort();
		print_verdict();
	end
	// The whole run needs roughly a tenth of this span.
	initial begin
		#300000;
		bad_count++;
		print_verdict();
	end
endmodule
